// ===== logic/wra_cfg.svh
// offsets, reset values, field positions and codes for the working-register and stack block
`ifndef WRA_CFG_SVH
`define WRA_CFG_SVH

// ------------------------------------------------------------
// system register offsets
// ------------------------------------------------------------
`define WRA_SLICE0_OFS 8'hd6
`define WRA_SLICE1_OFS 8'hd7
`define WRA_SPH_OFS 8'hd8
`define WRA_SPL_OFS 8'hd9

// ------------------------------------------------------------
// reset values and field positions
// ------------------------------------------------------------
`define WRA_SLICE0_RST 8'hc0
`define WRA_SLICE1_RST 8'hc8
`define WRA_SLICE_HI_OFS 8'h08
`define WRA_WORK_NIB 4'hc
`define WRA_SET1_TOP 2'h3
`define WRA_EXT_STACK_BIT 1
`define WRA_PTR_SEL_BIT 3

`endif

// ===== logic/wra_pkg.sv
// types of the working-register and stack block
package wra_pkg;

  // ------------------------------------------------------------
  // operand address modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    WRA_MODE_REG8 = 2'b00,
    WRA_MODE_WORK4 = 2'b01,
    WRA_MODE_IND = 2'b10
  } wra_mode_e;

  // ------------------------------------------------------------
  // stack commands
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    WRA_CMD_NONE = 4'h0,
    WRA_CMD_PUSH = 4'h1,
    WRA_CMD_POP = 4'h2,
    WRA_CMD_CALL = 4'h3,
    WRA_CMD_RET = 4'h4,
    WRA_CMD_INT = 4'h5,
    WRA_CMD_INTERRUPT_RETURN = 4'h6,
    WRA_CMD_UPUSH_INC = 4'h7,
    WRA_CMD_UPUSH_DEC = 4'h8,
    WRA_CMD_UPOP_INC = 4'h9,
    WRA_CMD_UPOP_DEC = 4'ha
  } wra_cmd_e;

  // ------------------------------------------------------------
  // slice pointer load selection
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    WRA_SRP_BOTH = 2'b00,
    WRA_SRP_ZERO = 2'b01,
    WRA_SRP_ONE = 2'b10
  } wra_srp_e;

  typedef enum logic [0:0] {
    WRA_ST_IDLE = 1'b0,
    WRA_ST_RUN = 1'b1
  } wra_state_e;

  // ------------------------------------------------------------
  // whole state of the block
  // ------------------------------------------------------------
  typedef struct packed {
    wra_state_e st;
    wra_cmd_e cmd;
    logic [1:0] step;
    logic [7:0] p0;
    logic [7:0] p1;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] flg;
    logic [7:0] dat;
    logic [7:0] upt;
    logic upt_we;
    logic done;
    logic ax_ack;
    logic [7:0] ax_addr;
    logic [7:0] ax_lo;
    logic ax_set2;
    logic ax_work;
  } wra_state_s;

endpackage : wra_pkg

// ===== logic/wra_regaddr_stack.sv
// working-register address former, slice pointers and system/user stack sequencer
`timescale 1ns/1ps
`include "wra_cfg.svh"

module wra_regaddr_stack (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // system register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // slice pointer load
  input wire logic srp_valid,
  input wire wra_pkg::wra_srp_e srp_sel,
  input wire logic [7:0] srp_value,
  // operand address translation
  input wire logic ax_req,
  input wire wra_pkg::wra_mode_e ax_mode,
  input wire logic [7:0] ax_op,
  input wire logic ax_pair,
  output logic ax_ack,
  output logic [7:0] ax_addr,
  output logic [7:0] ax_addr_lo,
  output logic ax_set2,
  output logic ax_work,
  // stack command
  input wire wra_pkg::wra_cmd_e stk_cmd,
  input wire logic [15:0] stk_pc_in,
  input wire logic [7:0] stk_flags_in,
  input wire logic [7:0] stk_data_in,
  input wire logic [7:0] stk_uptr_in,
  input wire logic [7:0] emt_value,
  output logic stk_busy,
  output logic stk_done,
  output logic [15:0] stk_pc_out,
  output logic [7:0] stk_flags_out,
  output logic [7:0] stk_data_out,
  output logic [7:0] stk_uptr_out,
  output logic stk_uptr_we,
  // stack memory
  output logic mem_en,
  output logic mem_we,
  output logic mem_ext,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);

  wra_pkg::wra_state_s s_q;
  wra_pkg::wra_state_s s_d;

  // ------------------------------------------------------------
  // stack area and pointer arithmetic
  // ------------------------------------------------------------
  logic ext_stack;
  logic [15:0] sp_dec;
  logic [15:0] sp_inc;
  logic is_push;
  logic last_step;
  logic user_op;

  assign ext_stack = emt_value[`WRA_EXT_STACK_BIT];

  always_comb begin
    if (ext_stack) begin
      sp_dec = s_q.sp - 16'h0001;
      sp_inc = s_q.sp + 16'h0001;
    end else begin
      // only the low byte moves, so the high byte stays usable as data
      sp_dec = {s_q.sp[15:8], s_q.sp[7:0] - 8'h01};
      sp_inc = {s_q.sp[15:8], s_q.sp[7:0] + 8'h01};
    end
  end

  always_comb begin
    case (s_q.cmd)
      wra_pkg::WRA_CMD_PUSH,
      wra_pkg::WRA_CMD_CALL,
      wra_pkg::WRA_CMD_INT,
      wra_pkg::WRA_CMD_UPUSH_INC,
      wra_pkg::WRA_CMD_UPUSH_DEC: is_push = 1'b1;
      default: is_push = 1'b0;
    endcase
  end

  always_comb begin
    case (s_q.cmd)
      wra_pkg::WRA_CMD_CALL,
      wra_pkg::WRA_CMD_RET: last_step = (s_q.step == 2'd1);
      wra_pkg::WRA_CMD_INT,
      wra_pkg::WRA_CMD_INTERRUPT_RETURN: last_step = (s_q.step == 2'd2);
      default: last_step = 1'b1;
    endcase
  end

  // user stacks live in the register file and never move the system pointer
  assign user_op = (s_q.cmd >= wra_pkg::WRA_CMD_UPUSH_INC);

  // ------------------------------------------------------------
  // stack memory access of the current step
  // ------------------------------------------------------------
  always_comb begin
    mem_en = (s_q.st == wra_pkg::WRA_ST_RUN);
    mem_we = mem_en & is_push;
    mem_ext = ext_stack & ~user_op;
    mem_wdata = s_q.dat;
    mem_addr = is_push ? sp_dec : s_q.sp;
    // internal stack sits in the register file, so the page byte must not reach the address
    if (!ext_stack) begin
      mem_addr[15:8] = 8'h00;
    end
    case (s_q.cmd)
      wra_pkg::WRA_CMD_UPUSH_INC: mem_addr = {8'h00, s_q.upt + 8'h01};
      wra_pkg::WRA_CMD_UPUSH_DEC: mem_addr = {8'h00, s_q.upt - 8'h01};
      wra_pkg::WRA_CMD_UPOP_INC,
      wra_pkg::WRA_CMD_UPOP_DEC: mem_addr = {8'h00, s_q.upt};
      default: mem_addr = mem_addr;
    endcase
    // low counter byte goes first, so the high byte lands nearer the top
    case (s_q.cmd)
      wra_pkg::WRA_CMD_CALL,
      wra_pkg::WRA_CMD_INT: begin
        case (s_q.step)
          2'd0: mem_wdata = s_q.pc[7:0];
          2'd1: mem_wdata = s_q.pc[15:8];
          default: mem_wdata = s_q.flg;
        endcase
      end
      default: mem_wdata = s_q.dat;
    endcase
  end

  // ------------------------------------------------------------
  // working-register address former
  // ------------------------------------------------------------
  function automatic logic [7:0] wra_work(input logic [3:0] sh, input logic [7:0] p0,
                                          input logic [7:0] p1);
    logic [7:0] ptr;
    ptr = sh[`WRA_PTR_SEL_BIT] ? p1 : p0;
    return {ptr[7:3], sh[2:0]};
  endfunction : wra_work

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] ea;
    logic work;
    ea = ax_op;
    work = 1'b0;
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.upt_we = 1'b0;
    s_d.ax_ack = 1'b0;

    // operand translation, one cycle
    if (ax_req) begin
      case (ax_mode)
        wra_pkg::WRA_MODE_WORK4: begin
          ea = wra_work(ax_op[3:0], s_q.p0, s_q.p1);
          work = 1'b1;
        end
        wra_pkg::WRA_MODE_REG8: begin
          if (ax_op[7:4] == `WRA_WORK_NIB) begin
            ea = wra_work(ax_op[3:0], s_q.p0, s_q.p1);
            work = 1'b1;
          end else begin
            ea = ax_op;
          end
        end
        wra_pkg::WRA_MODE_IND: begin
          // indirect and indexed addresses are never relocated by the slice pointers
          ea = ax_op;
        end
        default: ea = ax_op;
      endcase
      if (ax_pair) begin
        ea = {ea[7:1], 1'b0};
      end
      s_d.ax_ack = 1'b1;
      s_d.ax_addr = ea;
      s_d.ax_lo = {ea[7:1], 1'b1};
      s_d.ax_work = work;
      // upper area through indirect/indexed access means set 2
      s_d.ax_set2 = (ax_mode == wra_pkg::WRA_MODE_IND) &&
                    (ea[7:6] == `WRA_SET1_TOP);
    end

    // system register writes while no stack command runs
    // a write that meets a running command is dropped, so the sequencer alone moves the pointer
    if (reg_wr && s_q.st == wra_pkg::WRA_ST_IDLE) begin
      case (reg_addr)
        `WRA_SLICE0_OFS: s_d.p0 = reg_wdata;
        `WRA_SLICE1_OFS: s_d.p1 = reg_wdata;
        `WRA_SPH_OFS: s_d.sp[15:8] = reg_wdata;
        `WRA_SPL_OFS: s_d.sp[7:0] = reg_wdata;
        default: s_d.sp = s_d.sp;
      endcase
    end

    // slice pointer load command
    if (srp_valid) begin
      case (srp_sel)
        wra_pkg::WRA_SRP_BOTH: begin
          s_d.p0 = {srp_value[7:4], 4'h0};
          s_d.p1 = {srp_value[7:4], 4'h0} | `WRA_SLICE_HI_OFS;
        end
        wra_pkg::WRA_SRP_ZERO: s_d.p0 = srp_value;
        wra_pkg::WRA_SRP_ONE: s_d.p1 = srp_value;
        default: s_d.p0 = s_d.p0;
      endcase
    end

    // ------------------------------------------------------------
    // stack sequencer, one byte per cycle
    // ------------------------------------------------------------
    case (s_q.st)
      wra_pkg::WRA_ST_IDLE: begin
        if (stk_cmd != wra_pkg::WRA_CMD_NONE) begin
          s_d.st = wra_pkg::WRA_ST_RUN;
          s_d.cmd = stk_cmd;
          s_d.step = 2'd0;
          s_d.pc = stk_pc_in;
          s_d.flg = stk_flags_in;
          s_d.dat = stk_data_in;
          s_d.upt = stk_uptr_in;
        end
      end
      wra_pkg::WRA_ST_RUN: begin
        s_d.step = s_q.step + 2'd1;
        if (!user_op) begin
          s_d.sp = is_push ? sp_dec : sp_inc;
        end
        case (s_q.cmd)
          wra_pkg::WRA_CMD_POP: s_d.dat = mem_rdata;
          wra_pkg::WRA_CMD_RET: begin
            if (s_q.step == 2'd0) begin
              s_d.pc[15:8] = mem_rdata;
            end else begin
              s_d.pc[7:0] = mem_rdata;
            end
          end
          wra_pkg::WRA_CMD_INTERRUPT_RETURN: begin
            case (s_q.step)
              2'd0: s_d.flg = mem_rdata;
              2'd1: s_d.pc[15:8] = mem_rdata;
              default: s_d.pc[7:0] = mem_rdata;
            endcase
          end
          wra_pkg::WRA_CMD_UPUSH_INC: s_d.upt = s_q.upt + 8'h01;
          wra_pkg::WRA_CMD_UPUSH_DEC: s_d.upt = s_q.upt - 8'h01;
          wra_pkg::WRA_CMD_UPOP_INC: begin
            s_d.dat = mem_rdata;
            s_d.upt = s_q.upt + 8'h01;
          end
          wra_pkg::WRA_CMD_UPOP_DEC: begin
            s_d.dat = mem_rdata;
            s_d.upt = s_q.upt - 8'h01;
          end
          default: s_d.dat = s_d.dat;
        endcase
        if (last_step) begin
          s_d.st = wra_pkg::WRA_ST_IDLE;
          s_d.cmd = wra_pkg::WRA_CMD_NONE;
          s_d.done = 1'b1;
          s_d.upt_we = user_op;
        end
      end
      default: s_d.st = wra_pkg::WRA_ST_IDLE;
    endcase

    // synchronous reset wins over everything above; the stack pointer keeps its value
    if (!nrst) begin
      s_d = '0;
      s_d.st = wra_pkg::WRA_ST_IDLE;
      s_d.cmd = wra_pkg::WRA_CMD_NONE;
      s_d.p0 = `WRA_SLICE0_RST;
      s_d.p1 = `WRA_SLICE1_RST;
      s_d.sp = s_q.sp;
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // reads are combinational, so a value written in one cycle is seen in the next
  always_comb begin
    reg_hit = 1'b1;
    case (reg_addr)
      `WRA_SLICE0_OFS: reg_rdata = s_q.p0;
      `WRA_SLICE1_OFS: reg_rdata = s_q.p1;
      `WRA_SPH_OFS: reg_rdata = s_q.sp[15:8];
      `WRA_SPL_OFS: reg_rdata = s_q.sp[7:0];
      default: begin
        reg_rdata = 8'h00;
        reg_hit = 1'b0;
      end
    endcase
  end

  assign ax_ack = s_q.ax_ack;
  assign ax_addr = s_q.ax_addr;
  assign ax_addr_lo = s_q.ax_lo;
  assign ax_set2 = s_q.ax_set2;
  assign ax_work = s_q.ax_work;
  assign stk_busy = (s_q.st == wra_pkg::WRA_ST_RUN);
  assign stk_done = s_q.done;
  assign stk_pc_out = s_q.pc;
  assign stk_flags_out = s_q.flg;
  assign stk_data_out = s_q.dat;
  assign stk_uptr_out = s_q.upt;
  assign stk_uptr_we = s_q.upt_we;

endmodule : wra_regaddr_stack

// ===== verification/wra_regaddr_stack_chk.sv
// assertion checker for the working-register and stack block
`timescale 1ns/1ps
module wra_regaddr_stack_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register and translation ports
  input wire logic [7:0] reg_addr,
  input wire logic reg_hit,
  input wire logic ax_req,
  input wire wra_pkg::wra_mode_e ax_mode,
  input wire logic [7:0] ax_op,
  input wire logic ax_pair,
  input wire logic ax_ack,
  input wire logic [7:0] ax_addr,
  input wire logic [7:0] ax_addr_lo,
  input wire logic ax_set2,
  input wire logic ax_work,
  // stack ports
  input wire wra_pkg::wra_cmd_e stk_cmd,
  input wire logic stk_busy,
  input wire logic stk_done,
  input wire logic [7:0] emt_value,
  input wire logic mem_en,
  input wire logic mem_we,
  input wire logic mem_ext,
  input wire logic [15:0] mem_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic go;
  // a stack command that the block takes
  assign go = (stk_cmd != wra_pkg::WRA_CMD_NONE) && !stk_busy;
  a_ack_timing: assert property (ax_req |=> ax_ack) else $error("ack late");
  a_short_ea: assert property (ax_req && ax_mode == wra_pkg::WRA_MODE_WORK4 |=>
    ax_work && ax_addr[2:1] == $past(ax_op[2:1]) && ax_addr[0] == ($past(ax_op[0]) && !$past(ax_pair)))
    else $error("short address wrong");
  a_full_work: assert property (ax_req && ax_mode == wra_pkg::WRA_MODE_REG8 |=>
    ax_work == ($past(ax_op[7:4]) == 4'hc)) else $error("working nibble wrong");
  a_pair_even: assert property (ax_ack && $past(ax_pair) |->
    !ax_addr[0] && ax_addr_lo == {ax_addr[7:1], 1'b1}) else $error("pair order wrong");
  a_no_set2: assert property (ax_req && ax_mode != wra_pkg::WRA_MODE_IND |=> !ax_set2)
    else $error("set2 reached");
  a_hit_map: assert property (reg_hit == (reg_addr inside {[8'hd6:8'hd9]})) else $error("hit wrong");
  a_stk_area: assert property (go && stk_cmd <= wra_pkg::WRA_CMD_INTERRUPT_RETURN |=>
    mem_en && mem_ext == $past(emt_value[1])) else $error("stack area wrong");
  a_call_seq: assert property (go && stk_cmd == wra_pkg::WRA_CMD_CALL |=>
    (mem_en && mem_we)[*2] ##1 stk_done) else $error("call sequence wrong");
  a_push_pre: assert property (go && stk_cmd == wra_pkg::WRA_CMD_CALL |=>
    ##1 mem_addr[7:0] == $past(mem_addr[7:0]) - 8'h01) else $error("push not decrementing");
  a_int_save: assert property (go && stk_cmd == wra_pkg::WRA_CMD_INT |=>
    (mem_en && mem_we)[*3] ##1 stk_done) else $error("interrupt save wrong");
  a_ret_pop: assert property (go && stk_cmd == wra_pkg::WRA_CMD_RET |=>
    (mem_en && !mem_we)[*2] ##1 stk_done) else $error("return sequence wrong");
  a_user_int: assert property (go && stk_cmd >= wra_pkg::WRA_CMD_UPUSH_INC |=>
    mem_en && !mem_ext) else $error("user stack not internal");
  a_int_page: assert property (mem_en && !mem_ext |-> mem_addr[15:8] == 8'h00)
    else $error("internal stack left page 0");
  c_int: cover property (go && stk_cmd == wra_pkg::WRA_CMD_INT);
  c_set2: cover property (ax_ack && ax_set2);
  c_work: cover property (ax_ack && ax_work);
  c_user: cover property (go && stk_cmd >= wra_pkg::WRA_CMD_UPUSH_INC);
endmodule : wra_regaddr_stack_chk

bind wra_regaddr_stack wra_regaddr_stack_chk u_wra_regaddr_stack_chk (.*);

// ===== verification/wra_mem_model.sv
// stack memory model on the far side of the block
`timescale 1ns/1ps
module wra_mem_model (
  // clock
  input wire logic core_clk,
  // memory port
  input wire logic mem_en,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  // outside a read cycle the data lines toggle every cycle
  always_comb begin
    if (mem_en && !mem_we) begin
      mem_rdata = mem[mem_addr];
    end else begin
      mem_rdata = ~last_q;
    end
  end
  always @(posedge core_clk) begin
    last_q <= mem_rdata;
    if (mem_en && mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule : wra_mem_model

// ===== verification/wra_regaddr_stack_bench.sv
// self-checking bench for the working-register and stack block
`timescale 1ns/1ps
module wra_regaddr_stack_bench;
  logic core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, srp_valid = 1'b0, ax_req = 1'b0, ax_pair = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, srp_value = 8'h00, ax_op = 8'h00, emt_value = 8'h00;
  logic [7:0] stk_flags_in = 8'h00, stk_data_in = 8'h00, stk_uptr_in = 8'h00;
  logic [15:0] stk_pc_in = 16'h0000;
  wra_pkg::wra_srp_e srp_sel = wra_pkg::WRA_SRP_BOTH;
  wra_pkg::wra_mode_e ax_mode = wra_pkg::WRA_MODE_REG8;
  wra_pkg::wra_cmd_e stk_cmd = wra_pkg::WRA_CMD_NONE;
  logic [7:0] reg_rdata, ax_addr, ax_addr_lo, stk_flags_out, stk_data_out, stk_uptr_out, mem_wdata, mem_rdata;
  logic reg_hit, ax_ack, ax_set2, ax_work, stk_busy, stk_done, stk_uptr_we, mem_en, mem_we, mem_ext;
  logic [15:0] stk_pc_out, mem_addr;
  int num_errors = 0;
  int num_checks = 0;
  wra_regaddr_stack u_wra_regaddr_stack (.*);
  wra_mem_model u_wra_mem_model (.*);
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic do_reset;
    nrst = 1'b0;
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_addr = a;
    #1;
    chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd
  task automatic xl(input wra_pkg::wra_mode_e m, input logic [7:0] op, input logic pr, input logic [7:0] ea,
                    input logic [2:0] fl);
    @(negedge core_clk);
    ax_mode = m;
    ax_op = op;
    ax_pair = pr;
    ax_req = 1'b1;
    @(negedge core_clk);
    ax_req = 1'b0;
    chk("ax_addr", {8'h00, ea}, {8'h00, ax_addr});
    chk("ack_work_set2", {13'h0000, fl}, {13'h0000, ax_ack, ax_work, ax_set2});
  endtask : xl
  task automatic stk(input wra_pkg::wra_cmd_e c, input logic [15:0] pc, input logic [7:0] fd);
    int n;
    @(negedge core_clk);
    stk_cmd = c;
    stk_pc_in = pc;
    stk_flags_in = fd;
    stk_data_in = fd;
    stk_uptr_in = fd;
    @(negedge core_clk);
    stk_cmd = wra_pkg::WRA_CMD_NONE;
    n = 0;
    while (stk_done !== 1'b1 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    chk("stk_done", 16'h0001, {15'h0000, stk_done});
    chk("stk_busy", 16'h0000, {15'h0000, stk_busy});
  endtask : stk
  task automatic t_ptrs;
    rd(8'hd6, 8'hc0);
    rd(8'hd7, 8'hc8);
    rd(8'hd5, 8'h00);
    chk("reg_hit", 16'h0000, {15'h0000, reg_hit});
    @(negedge core_clk);
    srp_value = 8'h75;
    srp_valid = 1'b1;
    @(negedge core_clk);
    srp_valid = 1'b0;
    rd(8'hd6, 8'h70);
    rd(8'hd7, 8'h78);
    do_reset();
    rd(8'hd7, 8'hc8);
    wr(8'hd6, 8'h70);
    wr(8'hd7, 8'ha0);
    rd(8'hd7, 8'ha0);
  endtask : t_ptrs
  task automatic t_xlate;
    xl(wra_pkg::WRA_MODE_WORK4, 8'h06, 1'b0, 8'h76, 3'b110);
    xl(wra_pkg::WRA_MODE_REG8, 8'hcb, 1'b0, 8'ha3, 3'b110);
    xl(wra_pkg::WRA_MODE_REG8, 8'h85, 1'b0, 8'h85, 3'b100);
    xl(wra_pkg::WRA_MODE_WORK4, 8'h0d, 1'b1, 8'ha4, 3'b110);
    chk("ax_addr_lo", 16'h00a5, {8'h00, ax_addr_lo});
    xl(wra_pkg::WRA_MODE_IND, 8'he0, 1'b0, 8'he0, 3'b101);
    xl(wra_pkg::WRA_MODE_REG8, 8'he0, 1'b0, 8'he0, 3'b100);
  endtask : t_xlate
  task automatic t_stack;
    wr(8'hd8, 8'h12);
    wr(8'hd9, 8'hff);
    stk(wra_pkg::WRA_CMD_PUSH, 16'h0000, 8'h5a);
    rd(8'hd9, 8'hfe);
    stk(wra_pkg::WRA_CMD_POP, 16'h0000, 8'h00);
    chk("stk_data_out", 16'h005a, {8'h00, stk_data_out});
    rd(8'hd9, 8'hff);
    wr(8'hd9, 8'h00);
    stk(wra_pkg::WRA_CMD_PUSH, 16'h0000, 8'h33);
    rd(8'hd9, 8'hff);
    rd(8'hd8, 8'h12);
    emt_value = 8'h02;
    wr(8'hd9, 8'h00);
    stk(wra_pkg::WRA_CMD_PUSH, 16'h0000, 8'h44);
    rd(8'hd8, 8'h11);
    stk(wra_pkg::WRA_CMD_POP, 16'h0000, 8'h00);
    chk("stk_data_out", 16'h0044, {8'h00, stk_data_out});
    rd(8'hd8, 8'h12);
    emt_value = 8'h00;
  endtask : t_stack
  task automatic t_calls;
    wr(8'hd9, 8'hff);
    stk(wra_pkg::WRA_CMD_CALL, 16'h1234, 8'h00);
    rd(8'hd9, 8'hfd);
    stk(wra_pkg::WRA_CMD_RET, 16'h0000, 8'h00);
    chk("stk_pc_out", 16'h1234, stk_pc_out);
    stk(wra_pkg::WRA_CMD_INT, 16'hbeef, 8'hc5);
    rd(8'hd9, 8'hfc);
    stk(wra_pkg::WRA_CMD_INTERRUPT_RETURN, 16'h0000, 8'h00);
    chk("stk_pc_out", 16'hbeef, stk_pc_out);
    chk("stk_flags_out", 16'h00c5, {8'h00, stk_flags_out});
  endtask : t_calls
  task automatic t_user;
    stk(wra_pkg::WRA_CMD_UPUSH_DEC, 16'h0000, 8'h40);
    chk("uptr_we_ptr", 16'h013f, {7'h00, stk_uptr_we, stk_uptr_out});
    stk(wra_pkg::WRA_CMD_UPOP_INC, 16'h0000, 8'h3f);
    chk("data_ptr", 16'h4040, {stk_data_out, stk_uptr_out});
    stk(wra_pkg::WRA_CMD_UPUSH_INC, 16'h0000, 8'h50);
    chk("uptr_we_ptr", 16'h0151, {7'h00, stk_uptr_we, stk_uptr_out});
    stk(wra_pkg::WRA_CMD_UPOP_DEC, 16'h0000, 8'h51);
    chk("data_ptr", 16'h5050, {stk_data_out, stk_uptr_out});
  endtask : t_user
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
  initial begin
    do_reset();
    t_ptrs();
    t_xlate();
    t_stack();
    t_calls();
    t_user();
    complete_run();
  end
endmodule : wra_regaddr_stack_bench
